/* File: logic/sdcm_core.sv */
// sdram device logic: command decode, bursts, precharge and power modes
`timescale 1ns/1ps

module sdcm_core #(
	parameter int ROW_BITS = sdcm_pkg::ROW_BITS,
	parameter int COL_BITS = sdcm_pkg::COL_BITS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_select_0,
	input wire logic bank_select_1,
	input wire logic [sdcm_pkg::ADDR_BITS-1:0] addr,
	// data pins and byte masks
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic [sdcm_pkg::DATA_BITS-1:0] dq_in,
	output logic [sdcm_pkg::DATA_BITS-1:0] dq_out,
	output logic [sdcm_pkg::MASK_BITS-1:0] dq_oe,
	// read word handshake with the receiver
	output logic rd_valid,
	input wire logic rd_ready,
	// status
	output logic [sdcm_pkg::BANKS-1:0] bank_open,
	output logic burst_busy,
	output logic in_clock_suspend,
	output logic in_power_down,
	output logic in_self_refresh,
	output logic refresh_done,
	output logic cmd_error
);

	localparam int BEAT_W = sdcm_pkg::DATA_BITS + sdcm_pkg::MASK_BITS;
	localparam int MEM_WORDS = sdcm_pkg::BANKS * (2 ** (ROW_BITS + COL_BITS));

	typedef struct packed {
		logic cke_q;
		sdcm_pkg::sdcm_pm_t pm;
		logic [sdcm_pkg::BANKS-1:0] act;
		logic [sdcm_pkg::BANKS-1:0][ROW_BITS-1:0] row;
		logic [2:0] len_code;
		logic ilv;
		logic rl3;
		logic b_act;
		logic b_wr;
		logic b_ap;
		logic [sdcm_pkg::BANK_BITS-1:0] b_bank;
		logic [COL_BITS-1:0] b_col;
		logic [COL_BITS:0] b_cnt;
		logic ap_pend;
		logic [sdcm_pkg::BANK_BITS-1:0] ap_bank;
		logic [1:0] ap_cnt;
		logic [1:0] dl_v;
		logic [1:0][BEAT_W-1:0] dl;
		logic err;
		logic ref_p;
	} sdcm_core_st_t;

	sdcm_core_st_t st_q;
	sdcm_core_st_t st_d;

	logic [sdcm_pkg::DATA_BITS-1:0] mem [0:MEM_WORDS-1];

	sdcm_pkg::sdcm_cmd_t cmd;
	logic [sdcm_pkg::BANK_BITS-1:0] bk;
	logic any_act;
	logic run;
	logic live;
	logic dl_adv;
	logic bt_go;
	logic bt_last;
	logic [COL_BITS-1:0] bt_col;
	logic [sdcm_pkg::BANK_BITS+ROW_BITS+COL_BITS-1:0] bt_idx;
	logic [sdcm_pkg::DATA_BITS-1:0] bt_rdata;
	logic buf_in_ready;
	logic [BEAT_W-1:0] buf_out;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// chip select high masks the strobes, so deselect reads as no-operation
	function automatic sdcm_pkg::sdcm_cmd_t cmd_of(input logic cs, input logic ras,
		input logic cas, input logic we);
		sdcm_pkg::sdcm_cmd_t c;
		c = sdcm_pkg::CMD_NOP;
		if (!cs) begin
			c = sdcm_pkg::sdcm_cmd_t'({cs, ras, cas, we});
		end
		return c;
	endfunction : cmd_of

	// beats in a burst; full page covers the whole column range
	function automatic logic [COL_BITS:0] blen(input logic [2:0] code);
		logic [COL_BITS:0] n;
		n = (COL_BITS+1)'(1) << COL_BITS;
		if (code == sdcm_pkg::BURST_LEN_1) begin
			n = (COL_BITS+1)'(1);
		end else if (code == sdcm_pkg::BURST_LEN_2) begin
			n = (COL_BITS+1)'(2);
		end else if (code == sdcm_pkg::BURST_LEN_4) begin
			n = (COL_BITS+1)'(4);
		end else if (code == sdcm_pkg::BURST_LEN_8) begin
			n = (COL_BITS+1)'(8);
		end
		return n;
	endfunction : blen

	// column of a beat: only the bits the burst covers move, no carry above
	function automatic logic [COL_BITS-1:0] col_at(input logic [COL_BITS-1:0] start,
		input logic [COL_BITS-1:0] cnt, input logic [2:0] code, input logic ilv);
		logic [COL_BITS-1:0] msk;
		logic [COL_BITS-1:0] off;
		logic [COL_BITS:0] len;
		len = blen(code);
		msk = COL_BITS'(len - (COL_BITS+1)'(1));
		if (ilv && code != sdcm_pkg::BURST_LEN_FULL) begin
			off = start ^ cnt;
		end else begin
			off = start + cnt;
		end
		return (start & ~msk) | (off & msk);
	endfunction : col_at

	////////////////////////////////////////////////////////////////////////////////
	// read word buffer: a stalled receiver backs up into the burst engine

	sdcm_pair_buf #(
		.WIDTH(BEAT_W)
	) u_rd_buf (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_valid(st_q.dl_v[1] && st_q.pm == sdcm_pkg::PM_RUN),
		.in_ready(buf_in_ready),
		.in_data(st_q.dl[1]),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(buf_out)
	);

	// a masked byte floats its lane while the word is on the pins
	assign dq_out = buf_out[sdcm_pkg::DATA_BITS-1:0];
	assign dq_oe = {2{rd_valid}} & ~buf_out[BEAT_W-1:sdcm_pkg::DATA_BITS];

	////////////////////////////////////////////////////////////////////////////////
	// combinational next state

	always_comb begin
		st_d = st_q;
		cmd = cmd_of(cs_n, ras_n, cas_n, we_n);
		bk = {bank_select_1, bank_select_0};
		any_act = |st_q.act;
		// suspend, power down and self refresh all freeze the core
		run = (st_q.pm == sdcm_pkg::PM_RUN);
		live = run && st_q.cke_q;
		st_d.cke_q = cke;
		st_d.err = 1'b0;
		st_d.ref_p = 1'b0;

		// latency line only moves when its tail can leave into the buffer
		dl_adv = run && !(st_q.dl_v[1] && !buf_in_ready);
		if (dl_adv) begin
			st_d.dl_v[1] = st_q.dl_v[0];
			st_d.dl[1] = st_q.dl[0];
			st_d.dl_v[0] = 1'b0;
		end

		// command decode; no-operation falls through and leaves bursts alone
		if (live) begin
			case (cmd)
				sdcm_pkg::CMD_ACT: begin
					if (st_q.act[bk]) begin
						st_d.err = 1'b1;
					end else begin
						st_d.act[bk] = 1'b1;
						st_d.row[bk] = addr[ROW_BITS-1:0];
					end
				end
				sdcm_pkg::CMD_READ, sdcm_pkg::CMD_WRITE: begin
					if (!st_q.act[bk]) begin
						st_d.err = 1'b1;
					end else begin
						st_d.b_act = 1'b1;
						st_d.b_wr = (cmd == sdcm_pkg::CMD_WRITE);
						st_d.b_ap = addr[sdcm_pkg::AP_BIT];
						st_d.b_bank = bk;
						st_d.b_col = addr[COL_BITS-1:0];
						st_d.b_cnt = '0;
					end
				end
				sdcm_pkg::CMD_PRE: begin
					if (addr[sdcm_pkg::AP_BIT]) begin
						st_d.act = '0;
					end else begin
						st_d.act[bk] = 1'b0;
					end
					// a burst cannot outlive its row
					if (!st_d.act[st_q.b_bank]) begin
						st_d.b_act = 1'b0;
					end
				end
				sdcm_pkg::CMD_MRS: begin
					if (any_act || st_q.b_act) begin
						st_d.err = 1'b1;
					end else begin
						st_d.len_code = addr[sdcm_pkg::MODE_LEN_LSB +: 3];
						st_d.ilv = addr[sdcm_pkg::MODE_ORDER_BIT];
						st_d.rl3 = (addr[sdcm_pkg::MODE_RL_LSB +: 3] == sdcm_pkg::RL_THREE);
					end
				end
				sdcm_pkg::CMD_REF: begin
					// with clock enable low this is self refresh, handled below
					if (cke) begin
						if (any_act || st_q.b_act) begin
							st_d.err = 1'b1;
						end else begin
							st_d.ref_p = 1'b1;
						end
					end
				end
				sdcm_pkg::CMD_BST: begin
					if (st_q.b_act) begin
						st_d.b_act = 1'b0;
					end else begin
						st_d.err = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// write recovery count runs to the internal precharge of the bank
		if (st_q.ap_pend && run) begin
			if (st_q.ap_cnt == 2'h1) begin
				st_d.ap_pend = 1'b0;
				st_d.act[st_q.ap_bank] = 1'b0;
			end else begin
				st_d.ap_cnt = st_q.ap_cnt - 2'h1;
			end
		end

		// one beat per running clock; reads also need room in the latency line
		bt_go = st_d.b_act && run && (st_d.b_wr || dl_adv);
		bt_col = col_at(st_d.b_col, st_d.b_cnt[COL_BITS-1:0], st_q.len_code, st_q.ilv);
		bt_idx = {st_d.b_bank, st_q.row[st_d.b_bank], bt_col};
		bt_rdata = mem[bt_idx];
		bt_last = (st_q.len_code != sdcm_pkg::BURST_LEN_FULL) &&
			(st_d.b_cnt + (COL_BITS+1)'(1) == blen(st_q.len_code));
		if (bt_go) begin
			if (!st_d.b_wr) begin
				// inject where the word meets the chosen read latency
				if (st_q.rl3) begin
					st_d.dl_v[0] = 1'b1;
					st_d.dl[0] = {high_byte_mask, low_byte_mask, bt_rdata};
				end else begin
					st_d.dl_v[1] = 1'b1;
					st_d.dl[1] = {high_byte_mask, low_byte_mask, bt_rdata};
				end
			end
			st_d.b_cnt = st_d.b_cnt + (COL_BITS+1)'(1);
			if (bt_last) begin
				st_d.b_act = 1'b0;
				if (st_d.b_ap && st_d.b_wr) begin
					st_d.ap_pend = 1'b1;
					st_d.ap_bank = st_d.b_bank;
					st_d.ap_cnt = sdcm_pkg::WR_RECOVERY_CLKS;
				end else if (st_d.b_ap) begin
					// last beat leaves the array a read latency before its data
					st_d.act[st_d.b_bank] = 1'b0;
				end
			end
		end

		// power and clock mode transitions, checked on clock enable edges
		case (st_q.pm)
			sdcm_pkg::PM_RUN: begin
				if (st_q.cke_q && !cke) begin
					if (cmd == sdcm_pkg::CMD_REF && !any_act && !st_q.b_act) begin
						st_d.pm = sdcm_pkg::PM_SREF;
					end else if (any_act || st_q.b_act || st_q.ap_pend) begin
						st_d.pm = sdcm_pkg::PM_SUSP;
					end else begin
						st_d.pm = sdcm_pkg::PM_PDOWN;
					end
				end
			end
			sdcm_pkg::PM_SUSP: begin
				if (cke) begin
					st_d.pm = sdcm_pkg::PM_RUN;
				end
			end
			sdcm_pkg::PM_PDOWN: begin
				if (cke) begin
					st_d.pm = sdcm_pkg::PM_RUN;
				end
			end
			sdcm_pkg::PM_SREF: begin
				if (cke) begin
					st_d.pm = sdcm_pkg::PM_RUN;
				end
			end
			default: begin
				st_d.pm = sdcm_pkg::PM_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.pm <= sdcm_pkg::PM_RUN;
			st_q.len_code <= sdcm_pkg::BURST_LEN_RST;
			st_q.ilv <= sdcm_pkg::ORDER_RST;
			st_q.rl3 <= sdcm_pkg::RL3_RST;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// array writes; a masked byte keeps its old contents

	always_ff @(posedge sys_clk) begin
		if (bt_go && st_d.b_wr) begin
			if (!low_byte_mask) begin
				mem[bt_idx][7:0] <= dq_in[7:0];
			end
			if (!high_byte_mask) begin
				mem[bt_idx][15:8] <= dq_in[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status outputs, all from the state register

	assign bank_open = st_q.act;
	assign burst_busy = st_q.b_act;
	assign in_clock_suspend = (st_q.pm == sdcm_pkg::PM_SUSP);
	assign in_power_down = (st_q.pm == sdcm_pkg::PM_PDOWN);
	assign in_self_refresh = (st_q.pm == sdcm_pkg::PM_SREF);
	assign refresh_done = st_q.ref_p;
	assign cmd_error = st_q.err;

endmodule : sdcm_core

/* File: pkg/sdcm_pkg.sv */
// shared constants and encodings of the sdram command and power mode block
package sdcm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// organisation
	localparam int BANKS = 4;
	localparam int BANK_BITS = 2;
	localparam int ROW_BITS = 12;
	localparam int COL_BITS = 8;
	localparam int ADDR_BITS = 12;
	localparam int DATA_BITS = 16;
	localparam int MASK_BITS = 2;

	////////////////////////////////////////////////////////////////////////////////
	// address bit that asks for precharge (auto or all banks)
	localparam int AP_BIT = 10;

	// mode field positions on the address pins at a mode set
	localparam int MODE_LEN_LSB = 0;
	localparam int MODE_ORDER_BIT = 3;
	localparam int MODE_RL_LSB = 4;

	// burst length codes
	localparam logic [2:0] BURST_LEN_1 = 3'h0;
	localparam logic [2:0] BURST_LEN_2 = 3'h1;
	localparam logic [2:0] BURST_LEN_4 = 3'h2;
	localparam logic [2:0] BURST_LEN_8 = 3'h3;
	localparam logic [2:0] BURST_LEN_FULL = 3'h7;

	// read latency code that selects three clocks; any other code gives two
	localparam logic [2:0] RL_THREE = 3'h3;

	// reset values of the mode settings
	localparam logic [2:0] BURST_LEN_RST = 3'h0;
	localparam logic ORDER_RST = 1'b0;
	localparam logic RL3_RST = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// timing counts in clocks
	localparam logic [1:0] WR_RECOVERY_CLKS = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// command codes as {cs, ras, cas, we}; deselect folds into no-operation
	typedef enum logic [3:0] {
		CMD_MRS = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_READ = 4'h5,
		CMD_BST = 4'h6,
		CMD_NOP = 4'h7
	} sdcm_cmd_t;

	// power and clock modes
	typedef enum logic [3:0] {
		PM_RUN = 4'b0001,
		PM_SUSP = 4'b0010,
		PM_PDOWN = 4'b0100,
		PM_SREF = 4'b1000
	} sdcm_pm_t;

endpackage : sdcm_pkg

/* File: logic/sdcm_pair_buf.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sdcm_pair_buf #(
	parameter int WIDTH = 18
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	typedef struct packed {
		logic [1:0][WIDTH-1:0] ent;
		logic [1:0] cnt;
	} sdcm_buf_st_t;

	sdcm_buf_st_t buf_q;
	sdcm_buf_st_t buf_d;
	logic pop;
	logic push;

	// full and empty come straight from the fill count
	assign in_ready = (buf_q.cnt != 2'h2);
	assign out_valid = (buf_q.cnt != 2'h0);
	assign out_data = buf_q.ent[0];

	////////////////////////////////////////////////////////////////////////////////
	// pop shifts the tail forward, then a push lands in the first free slot
	always_comb begin
		buf_d = buf_q;
		pop = out_valid && out_ready;
		push = in_valid && in_ready;
		if (pop) begin
			buf_d.ent[0] = buf_q.ent[1];
			buf_d.cnt = buf_q.cnt - 2'h1;
		end
		if (push) begin
			buf_d.ent[buf_d.cnt[0]] = in_data;
			buf_d.cnt = buf_d.cnt + 2'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			buf_q <= '0;
		end else begin
			buf_q <= buf_d;
		end
	end

endmodule : sdcm_pair_buf

/* File: verification/sdcm_props.sv */
// assertion checker for the sdram command and power mode block
`timescale 1ns/1ps
module sdcm_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_select_0,
	input wire logic bank_select_1,
	input wire logic [sdcm_pkg::ADDR_BITS-1:0] addr,
	// read side and status
	input wire logic [sdcm_pkg::MASK_BITS-1:0] dq_oe,
	input wire logic rd_valid,
	input wire logic rd_ready,
	input wire logic [sdcm_pkg::BANKS-1:0] bank_open,
	input wire logic burst_busy,
	input wire logic in_clock_suspend,
	input wire logic in_power_down,
	input wire logic in_self_refresh,
	input wire logic refresh_done,
	input wire logic cmd_error
);
	logic cke_q;
	logic [3:0] code;
	logic run;
	logic idle;
	logic [1:0] bk;
	logic lowp;

	// own copy of the prior clock enable; cleared by reset like the device's
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			cke_q <= 1'b0;
		else
			cke_q <= cke;
	end

	// decode context: commands count only when running with prior enable high
	assign code = {cs_n, ras_n, cas_n, we_n};
	assign run = cke_q && !in_clock_suspend && !in_power_down && !in_self_refresh;
	assign idle = (bank_open == 4'h0) && !burst_busy;
	assign bk = {bank_select_1, bank_select_0};
	assign lowp = in_clock_suspend || in_power_down || in_self_refresh;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_cmd(logic [3:0] c);
		run && cke && code == c;
	endsequence

	property p_desel; run && cs_n |=> !cmd_error && !refresh_done; endproperty
	a_desel: assert property (p_desel) else $error("deselect had an effect");
	property p_ref; s_cmd(sdcm_pkg::CMD_REF) ##0 idle |=> refresh_done; endproperty
	a_ref: assert property (p_ref) else $error("refresh not done");
	property p_act; s_cmd(sdcm_pkg::CMD_ACT) ##0 !bank_open[bk] |=> bank_open[$past(bk)];
	endproperty
	a_act: assert property (p_act) else $error("bank not opened");
	property p_pre; s_cmd(sdcm_pkg::CMD_PRE) ##0 addr[10] |=> bank_open == 4'h0; endproperty
	a_pre: assert property (p_pre) else $error("banks left open");
	property p_rd_idle; s_cmd(sdcm_pkg::CMD_READ) ##0 !bank_open[bk] |=> cmd_error; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("idle read not refused");
	property p_pd; run && !cke && (cs_n || code == sdcm_pkg::CMD_NOP) && idle |=> in_power_down;
	endproperty
	a_pd: assert property (p_pd) else $error("power down not entered");
	property p_sref; run && !cke && code == sdcm_pkg::CMD_REF && idle |=> in_self_refresh;
	endproperty
	a_sref: assert property (p_sref) else $error("self refresh not entered");
	property p_susp; run && !cke && bank_open != 4'h0 |=> in_clock_suspend; endproperty
	a_susp: assert property (p_susp) else $error("suspend not entered");
	property p_exit; lowp && cke |=> !lowp; endproperty
	a_exit: assert property (p_exit) else $error("low power mode kept");
	property p_oe; !rd_valid |-> dq_oe == 2'h0; endproperty
	a_oe: assert property (p_oe) else $error("data driven without a word");
	property p_stall; rd_valid && !rd_ready |=> rd_valid; endproperty
	a_stall: assert property (p_stall) else $error("read word lost");
endmodule : sdcm_props

/* File: verification/sdcm_ctl_model.sv */
// memory controller model: drives the command pins and takes read words
`timescale 1ns/1ps
module sdcm_ctl_model (
	// clock
	input wire logic sys_clk,
	// command pins toward the device
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic bank_select_0,
	output logic bank_select_1,
	output logic [11:0] addr,
	// data and masks
	output logic low_byte_mask,
	output logic high_byte_mask,
	output logic [15:0] dq_in,
	output logic rd_ready
);
	logic stall = 1'b0;
	int seed = 32'h4387feef;

	// quiet pins at time zero, clock enable low as during power up
	initial begin
		cke = 1'b0;
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		{bank_select_1, bank_select_0} = 2'h0;
		addr = 12'h0;
		dq_in = 16'h0;
		{high_byte_mask, low_byte_mask} = 2'h0;
		rd_ready = 1'b1;
	end

	// receiver: random stalls when asked, so the buffer fills and drains
	always @(negedge sys_clk)
		rd_ready <= stall ? ($random(seed) % 2 == 0) : 1'b1;

	function automatic logic [15:0] rnd();
		return 16'($random(seed));
	endfunction : rnd

	// one command cycle; callers keep legal order and spacing
	task automatic cmd(input logic k, input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [15:0] d, input logic [1:0] m);
		@(negedge sys_clk);
		cke <= k;
		{cs_n, ras_n, cas_n, we_n} <= c;
		{bank_select_1, bank_select_0} <= b;
		addr <= a;
		dq_in <= d;
		{high_byte_mask, low_byte_mask} <= m;
	endtask : cmd
endmodule : sdcm_ctl_model

/* File: verification/sdcm_core_tb.sv */
// testbench for the sdram command and power mode block
`timescale 1ns/1ps
module sdcm_core_tb;
	logic sys_clk, sys_rst, cke, cs_n, ras_n, cas_n, we_n, bank_select_0, bank_select_1;
	logic low_byte_mask, high_byte_mask, rd_valid, rd_ready, burst_busy, cmd_error;
	logic in_clock_suspend, in_power_down, in_self_refresh, refresh_done;
	logic [11:0] addr;
	logic [15:0] dq_in, dq_out;
	logic [1:0] dq_oe;
	logic [3:0] bank_open;
	int n_mismatch = 0;
	int tests_run = 0;
	bit ilv = 1'b0;
	logic [15:0] mem [int];
	logic [15:0] exp_q [$];
	logic [1:0] oe_q [$];

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	sdcm_core #(.ROW_BITS(4), .COL_BITS(8)) DUT (.sys_clk, .sys_rst, .cke, .cs_n, .ras_n,
		.cas_n, .we_n, .bank_select_0, .bank_select_1, .addr, .low_byte_mask, .high_byte_mask,
		.dq_in, .dq_out, .dq_oe, .rd_valid, .rd_ready, .bank_open, .burst_busy,
		.in_clock_suspend, .in_power_down, .in_self_refresh, .refresh_done, .cmd_error);
	sdcm_ctl_model ctl (.sys_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_0,
		.bank_select_1, .addr, .low_byte_mask, .high_byte_mask, .dq_in, .rd_ready);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// burst column of beat i, length four
	function automatic int col(int c, int i);
		return ilv ? c ^ i : (c & ~3) | ((c + i) & 3);
	endfunction : col

	task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
		ctl.cmd(1'b1, c, b, a, ctl.rnd(), 2'h0);
	endtask : op

	// four-beat write to bank 0; a set mask bit at beat 1 keeps that stored byte
	task automatic wr(input int c, input bit ap, input logic [1:0] m0);
		logic [15:0] d;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			d = ctl.rnd();
			m = (i == 1) ? m0 : 2'h0;
			ctl.cmd(1'b1, i ? sdcm_pkg::CMD_NOP : sdcm_pkg::CMD_WRITE, 2'h0,
				12'(c) | (ap ? 12'h400 : 12'h0), d, m);
			if (i == 3) chk(16'(burst_busy), 16'h1);
			if (!m[0]) mem[col(c, i)][7:0] = d[7:0];
			if (!m[1]) mem[col(c, i)][15:8] = d[15:8];
		end
	endtask : wr

	// read burst from bank 0, masks on the first beat only; nops keep it running
	task automatic rd(input int c, input logic [1:0] m);
		ctl.cmd(1'b1, sdcm_pkg::CMD_READ, 2'h0, 12'(c), ctl.rnd(), m);
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back(mem[col(c, i)]);
			oe_q.push_back(i ? 2'h3 : ~m);
		end
		for (int w = 0; w < 60 && exp_q.size() > 0; w++) op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'(exp_q.size()), 16'h0);
	endtask : rd

	// every word the receiver takes is matched in burst order
	always @(posedge sys_clk)
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			chk(dq_out, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
			chk(16'(dq_oe), 16'(oe_q.size() > 0 ? oe_q.pop_front() : 2'hx));
		end

	////////////////////////////////////////
	// main sequence
	initial begin
		sys_rst = 1'b1;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		// length four, sequential, latency two; wrap check reads from column 6
		op(sdcm_pkg::CMD_MRS, 2'h0, 12'h002);
		op(sdcm_pkg::CMD_ACT, 2'h0, 12'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'(bank_open), 16'h1);
		wr(4, 1'b0, 2'h0);
		wr(4, 1'b0, 2'h2);
		rd(6, 2'h0);
		$display("sequential burst done");
		// refused commands, then a deselect that carries a read code
		op(sdcm_pkg::CMD_READ, 2'h1, 12'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'(cmd_error), 16'h1);
		op(sdcm_pkg::CMD_REF, 2'h0, 12'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'(cmd_error), 16'h1);
		ctl.cmd(1'b1, 4'hd, 2'h1, 12'h0, ctl.rnd(), 2'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'({cmd_error, rd_valid}), 16'h0);
		op(sdcm_pkg::CMD_ACT, 2'h1, 12'h0);
		op(sdcm_pkg::CMD_PRE, 2'h0, 12'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'(bank_open), 16'h2);
		// suspend with a bank open; a precharge meanwhile is ignored
		ctl.cmd(1'b0, sdcm_pkg::CMD_NOP, 2'h0, 12'h0, 16'h0, 2'h0);
		ctl.cmd(1'b0, sdcm_pkg::CMD_PRE, 2'h0, 12'h400, 16'h0, 2'h0);
		chk(16'(in_clock_suspend), 16'h1);
		ctl.cmd(1'b1, sdcm_pkg::CMD_NOP, 2'h0, 12'h0, 16'h0, 2'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'({in_clock_suspend, bank_open}), 16'h2);
		op(sdcm_pkg::CMD_PRE, 2'h0, 12'h400);
		op(sdcm_pkg::CMD_REF, 2'h0, 12'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'({bank_open, refresh_done}), 16'h1);
		$display("decode and suspend done");
		// power down, then self refresh with an activate that must be ignored
		ctl.cmd(1'b0, sdcm_pkg::CMD_NOP, 2'h0, 12'h0, 16'h0, 2'h0);
		ctl.cmd(1'b0, sdcm_pkg::CMD_NOP, 2'h0, 12'h0, 16'h0, 2'h0);
		chk(16'(in_power_down), 16'h1);
		ctl.cmd(1'b1, sdcm_pkg::CMD_NOP, 2'h0, 12'h0, 16'h0, 2'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'(in_power_down), 16'h0);
		ctl.cmd(1'b0, sdcm_pkg::CMD_REF, 2'h0, 12'h0, 16'h0, 2'h0);
		ctl.cmd(1'b0, sdcm_pkg::CMD_ACT, 2'h0, 12'h0, 16'h0, 2'h0);
		chk(16'(in_self_refresh), 16'h1);
		ctl.cmd(1'b1, sdcm_pkg::CMD_NOP, 2'h0, 12'h0, 16'h0, 2'h0);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'({in_self_refresh, bank_open}), 16'h0);
		$display("power modes done");
		// interleaved, latency three, receiver stalling; then write with auto precharge
		op(sdcm_pkg::CMD_MRS, 2'h0, 12'h03a);
		ilv = 1'b1;
		op(sdcm_pkg::CMD_ACT, 2'h0, 12'h0);
		ctl.stall = 1'b1;
		rd(5, 2'h1);
		ctl.stall = 1'b0;
		wr(8, 1'b1, 2'h0);
		repeat (2) op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'({burst_busy, bank_open}), 16'h1);
		op(sdcm_pkg::CMD_NOP, 2'h0, 12'h0);
		chk(16'(bank_open), 16'h0);
		$display("interleave and auto precharge done");
		summarize();
	end

	// watchdog, far beyond the fewer than two hundred cycles the sequence needs
	initial begin
		#(25 * 3000);
		n_mismatch++;
		summarize();
	end
endmodule : sdcm_core_tb

bind sdcm_core sdcm_props chk_i (.sys_clk, .sys_rst, .cke, .cs_n, .ras_n, .cas_n, .we_n,
	.bank_select_0, .bank_select_1, .addr, .dq_oe, .rd_valid, .rd_ready, .bank_open,
	.burst_busy, .in_clock_suspend, .in_power_down, .in_self_refresh, .refresh_done,
	.cmd_error);
